//--- src/cell_average.sv
// Purpose: averages 32 samples of one cell voltage
// Assumes: one sample offered per valid pulse, in mV
// Notes: result clamped to measuring span
`timescale 1ns/1ps
`include "charge_cfg.svh"
module cell_average (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sample_valid,
  input wire logic [15:0] sample_mv,
  input wire logic publish,
  output logic [15:0] avg_mv
);
  logic [20:0] sum_reg;
  logic [5:0] count_reg;
  logic [15:0] mean;

  always_comb begin
    mean = sum_reg[20:5];
    if (mean < `CELL_MIN_MV) begin
      mean = `CELL_MIN_MV;
    end else if (mean > `CELL_MAX_MV) begin
      mean = `CELL_MAX_MV;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sum_reg <= 21'h0;
      count_reg <= 6'h0;
      avg_mv <= `CELL_MIN_MV;
    end else if (publish) begin
      // Partial bursts are dropped rather than published
      if (count_reg == 6'(`CELL_SAMPLES)) begin
        avg_mv <= mean;
      end
      sum_reg <= 21'h0;
      count_reg <= 6'h0;
    end else if (sample_valid && count_reg != 6'(`CELL_SAMPLES)) begin
      sum_reg <= sum_reg + {5'h0, sample_mv};
      count_reg <= count_reg + 6'h1;
    end
  end
endmodule

//--- src/charge_cfg.svh
// Purpose: constants for the charge stage controller
// Assumes: pclk at 250 MHz, APB registers, 32-bit words
// Notes: voltages in mV, currents in 0.1 A, temperatures in deg C
`ifndef CHARGE_CFG_SVH
`define CHARGE_CFG_SVH
`define CLK_MHZ 250
`define CELL_PERIOD_US 31250
`define CELL_PERIOD_CYC (`CELL_PERIOD_US * `CLK_MHZ)
`define CELL_SAMPLES 32
`define CUR_PERIOD_US 1000
`define CUR_PERIOD_CYC (`CUR_PERIOD_US * `CLK_MHZ)
`define TEMP_PERIOD_MS 500
`define TEMP_PERIOD_CYC (`TEMP_PERIOD_MS * 1000 * `CLK_MHZ)
`define CAN_TIMEOUT_S 15
`define CAN_TIMEOUT_CYC (`CAN_TIMEOUT_S * 32'h000f4240 * `CLK_MHZ)
`define BAL_MARGIN_MV 16'h000a
`define CELL_MIN_MV 16'h03e8
`define CELL_MAX_MV 16'h1194
`define CUR_LIMIT_DA 16'sh02ee
`define N_CELLS 16
`define N_TEMPS 5
`define N_CAN_MODELS 4
// Register byte offsets
`define REG_CTRL 12'h000
`define REG_MAX_CELL 12'h004
`define REG_MIN_CELL 12'h008
`define REG_PRECHG 12'h00c
`define REG_RECHG 12'h010
`define REG_DISBAL 12'h014
`define REG_MIN_TEMP 12'h018
`define REG_MAX_CUR 12'h01c
`define REG_PRE_CUR 12'h020
`define REG_CAPACITY 12'h024
`define REG_STATUS 12'h028
`define REG_CHARGE 12'h02c
`define REG_MINMAX 12'h030
`define REG_BAL 12'h034
`define REG_REQ 12'h038
// Control fields
`define CTRL_START 0
`define CTRL_CAN_MODE 1
`define CTRL_DET_LSB 4
`define CTRL_ERR_CLR 8
// Reset values
`define RST_MAX_CELL 16'h1068
`define RST_MIN_CELL 16'h0bb8
`define RST_PRECHG 16'h0c1c
`define RST_RECHG 16'h1004
`define RST_DISBAL 16'h000a
`define RST_MIN_TEMP 8'sh00
`define RST_MAX_CUR 16'h0064
`define RST_PRE_CUR 16'h000a
`define RST_CAPACITY 16'h0064
`endif

//--- src/charge_pkg.sv
package charge_pkg;
  typedef enum logic [2:0] {
    st_idle, st_preheat, st_precharge, st_charging, st_balancing, st_finished, st_error
  } stage_t;
  typedef enum logic [1:0] {bal_charge, bal_drain} bal_phase_t;
endpackage

//--- src/charge_stage_ctrl.sv
// Purpose: charge stage machine with APB configuration
// Assumes: measured values arrive synchronous to pclk
// Notes: protections and CAN framing live outside this block
`timescale 1ns/1ps
`include "charge_cfg.svh"
module charge_stage_ctrl #(
  parameter int CELL_PERIOD = `CELL_PERIOD_CYC,
  parameter int CUR_PERIOD = `CUR_PERIOD_CYC,
  parameter int TEMP_PERIOD = `TEMP_PERIOD_CYC,
  parameter int unsigned CAN_TIMEOUT = `CAN_TIMEOUT_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cell_sample_valid,
  input wire logic [`N_CELLS*16-1:0] cell_sample_mv,
  input wire logic cur_valid,
  input wire logic signed [15:0] cur_da,
  input wire logic signed [`N_TEMPS*8-1:0] temp_c,
  input wire logic critical_fault,
  input wire logic mains_present_input,
  input wire logic can_rx_valid,
  input wire logic [1:0] can_rx_model,
  output logic cell_sample_start,
  output logic temp_sample_start,
  output logic charger_enable,
  output logic heater_on,
  output logic contactor_close,
  output logic can_req_valid,
  output logic [15:0] can_req_mv,
  output logic [15:0] can_req_da,
  output logic [`N_CELLS-1:0] shunt_on,
  output logic [2:0] stage
);
  ////////////////////////////////////////////////////////////////////////////
  logic cell_tick;
  logic cur_tick;
  logic temp_tick;
  logic [`N_CELLS*16-1:0] cell_mv;
  charge_pkg::stage_t stage_reg;
  charge_pkg::stage_t stage_next;
  charge_pkg::bal_phase_t phase_reg;
  logic start_reg;
  logic can_mode_reg;
  logic err_reg;
  logic [`N_CAN_MODELS-1:0] det_en_reg;
  // Configuration, frozen while charging
  logic [15:0] max_cell_reg;
  logic [15:0] min_cell_reg;
  logic [15:0] prechg_reg;
  logic [15:0] rechg_reg;
  logic [15:0] disbal_reg;
  logic [15:0] max_cur_reg;
  logic [15:0] pre_cur_reg;
  logic [15:0] capacity_reg;
  logic [15:0] bal_thr_reg;
  logic signed [7:0] min_temp_reg;
  logic signed [47:0] charge_reg;
  logic [31:0] silence_reg;
  logic can_conn_reg;
  logic [15:0] hi_mv;
  logic [15:0] lo_mv;
  logic signed [7:0] cold_c;
  logic charging;
  logic connected;
  logic [7:0] soc_pct;

  function automatic logic [15:0] cell_of(input logic [`N_CELLS*16-1:0] v, input int i);
    cell_of = v[i*16 +: 16];
  endfunction

  rate_tick #(.PERIOD(CELL_PERIOD)) u_cell_tick (
    .pclk(pclk),
    .presetn(presetn),
    .tick(cell_tick)
  );
  rate_tick #(.PERIOD(TEMP_PERIOD)) u_temp_tick (
    .pclk(pclk),
    .presetn(presetn),
    .tick(temp_tick)
  );
  rate_tick #(.PERIOD(CUR_PERIOD)) u_cur_tick (
    .pclk(pclk),
    .presetn(presetn),
    .tick(cur_tick)
  );

  genvar gi;
  generate
    for (gi = 0; gi < `N_CELLS; gi++) begin : g_cell
      cell_average u_avg (
        .pclk(pclk),
        .presetn(presetn),
        .sample_valid(cell_sample_valid),
        .sample_mv(cell_sample_mv[gi*16 +: 16]),
        .publish(cell_tick),
        .avg_mv(cell_mv[gi*16 +: 16])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Extremes of cells and sensors
  always_comb begin
    hi_mv = cell_of(cell_mv, 0);
    lo_mv = cell_of(cell_mv, 0);
    for (int i = 1; i < `N_CELLS; i++) begin
      if (cell_of(cell_mv, i) > hi_mv) hi_mv = cell_of(cell_mv, i);
      if (cell_of(cell_mv, i) < lo_mv) lo_mv = cell_of(cell_mv, i);
    end
    cold_c = temp_c[7:0];
    for (int i = 1; i < `N_TEMPS; i++) begin
      if ($signed(temp_c[i*8 +: 8]) < cold_c) cold_c = temp_c[i*8 +: 8];
    end
  end

  assign charging = stage_reg != charge_pkg::st_idle;
  assign connected = can_mode_reg ? can_conn_reg : mains_present_input;

  ////////////////////////////////////////////////////////////////////////////
  // Sampling strobes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cell_sample_start <= 1'b0;
      temp_sample_start <= 1'b0;
    end else begin
      cell_sample_start <= cell_tick;
      temp_sample_start <= temp_tick;
    end
  end

  // Coulomb counter, in 0.1 A times 1 ms units
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      charge_reg <= 48'sh0;
    end else if (cur_valid) begin
      if (cur_da <= `CUR_LIMIT_DA && cur_da >= -`CUR_LIMIT_DA) begin
        charge_reg <= charge_reg + 48'(cur_da);
      end
    end
  end

  // 1 Ah = 36000000 units; percent = units / (360000 * capacity)
  always_comb begin
    logic [47:0] full;
    full = 48'(capacity_reg) * 48'h57e40;
    if (charge_reg <= 0 || full == 48'h0) soc_pct = 8'h0;
    else if (48'(charge_reg) >= full * 48'h64) soc_pct = 8'h64;
    else soc_pct = 8'(48'(charge_reg) / full);
  end

  ////////////////////////////////////////////////////////////////////////////
  // CAN charger presence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      silence_reg <= 32'h0;
      can_conn_reg <= 1'b0;
    end else if (can_rx_valid && det_en_reg[can_rx_model]) begin
      silence_reg <= 32'h0;
      can_conn_reg <= 1'b1;
    end else if (silence_reg >= 32'(CAN_TIMEOUT)) begin
      can_conn_reg <= 1'b0;
    end else begin
      silence_reg <= silence_reg + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stage selection
  always_comb begin
    stage_next = stage_reg;
    if (!start_reg || !connected) begin
      stage_next = charge_pkg::st_idle;
    end else if (err_reg || critical_fault) begin
      stage_next = charge_pkg::st_error;
    end else if (stage_reg == charge_pkg::st_finished) begin
      if (lo_mv < rechg_reg) stage_next = charge_pkg::st_charging;
    end else if (cold_c < min_temp_reg) begin
      stage_next = charge_pkg::st_preheat;
    end else if (lo_mv < prechg_reg) begin
      stage_next = charge_pkg::st_precharge;
    end else if (stage_reg == charge_pkg::st_balancing) begin
      if (phase_reg == charge_pkg::bal_drain && (hi_mv - lo_mv) < disbal_reg) begin
        stage_next = charge_pkg::st_finished;
      end
    end else if (hi_mv >= max_cell_reg) begin
      stage_next = charge_pkg::st_balancing;
    end else begin
      stage_next = charge_pkg::st_charging;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_reg <= charge_pkg::st_idle;
    end else begin
      stage_reg <= stage_next;
    end
  end

  // Error latches until cleared and the fault is gone; set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_reg <= 1'b0;
    end else if (critical_fault && charging) begin
      err_reg <= 1'b1;
    end else if (psel && penable && pwrite && paddr == `REG_CTRL && pwdata[`CTRL_ERR_CLR]) begin
      err_reg <= 1'b0;
    end
  end

  // Balancing passes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg <= charge_pkg::bal_charge;
      bal_thr_reg <= `RST_MAX_CELL;
    end else if (stage_reg != charge_pkg::st_balancing) begin
      phase_reg <= charge_pkg::bal_charge;
      bal_thr_reg <= max_cell_reg;
    end else if (phase_reg == charge_pkg::bal_charge) begin
      if (hi_mv > max_cell_reg + `BAL_MARGIN_MV) begin
        phase_reg <= charge_pkg::bal_drain;
        // Lowest cell plus spread, capped at the maximum
        bal_thr_reg <= (lo_mv + disbal_reg > max_cell_reg) ? max_cell_reg : lo_mv + disbal_reg;
      end
    end else if (hi_mv <= bal_thr_reg && (hi_mv - lo_mv) >= disbal_reg) begin
      phase_reg <= charge_pkg::bal_charge;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      charger_enable <= 1'b0;
      heater_on <= 1'b0;
      contactor_close <= 1'b0;
      can_req_valid <= 1'b0;
      can_req_mv <= 16'h0;
      can_req_da <= 16'h0;
      shunt_on <= '0;
      stage <= 3'h0;
    end else begin
      stage <= stage_reg;
      heater_on <= stage_reg == charge_pkg::st_preheat;
      contactor_close <= charging && stage_reg != charge_pkg::st_finished
                         && stage_reg != charge_pkg::st_error;
      charger_enable <= !can_mode_reg && (stage_reg == charge_pkg::st_precharge
        || stage_reg == charge_pkg::st_charging || (stage_reg == charge_pkg::st_balancing
        && phase_reg == charge_pkg::bal_charge));
      can_req_valid <= can_mode_reg && can_conn_reg && cur_tick;
      // Pack voltage in 10 mV steps; whole mV would overflow 16 bits
      can_req_mv <= 16'((32'(max_cell_reg) * 32'(`N_CELLS)) / 32'h0000000a);
      case (stage_reg)
        charge_pkg::st_precharge: can_req_da <= pre_cur_reg;
        charge_pkg::st_charging: can_req_da <= max_cur_reg;
        charge_pkg::st_balancing:
          can_req_da <= (phase_reg == charge_pkg::bal_charge) ? pre_cur_reg : 16'h0;
        default: can_req_da <= 16'h0;
      endcase
      for (int i = 0; i < `N_CELLS; i++) begin
        shunt_on[i] <= stage_reg == charge_pkg::st_balancing && cell_of(cell_mv, i) > bal_thr_reg
                       && (cell_of(cell_mv, i) - lo_mv) > disbal_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB configuration; parameters locked while charging
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_reg <= 1'b0;
      can_mode_reg <= 1'b0;
      det_en_reg <= '0;
      max_cell_reg <= `RST_MAX_CELL;
      min_cell_reg <= `RST_MIN_CELL;
      prechg_reg <= `RST_PRECHG;
      rechg_reg <= `RST_RECHG;
      disbal_reg <= `RST_DISBAL;
      min_temp_reg <= `RST_MIN_TEMP;
      max_cur_reg <= `RST_MAX_CUR;
      pre_cur_reg <= `RST_PRE_CUR;
      capacity_reg <= `RST_CAPACITY;
    end else if (psel && penable && pwrite) begin
      if (paddr == `REG_CTRL) begin
        start_reg <= pwdata[`CTRL_START];
        if (!charging) begin
          can_mode_reg <= pwdata[`CTRL_CAN_MODE];
          det_en_reg <= pwdata[`CTRL_DET_LSB +: `N_CAN_MODELS];
        end
      end else if (!charging) begin
        case (paddr)
          `REG_MAX_CELL: max_cell_reg <= pwdata[15:0];
          `REG_MIN_CELL: min_cell_reg <= pwdata[15:0];
          `REG_PRECHG: prechg_reg <= pwdata[15:0];
          `REG_RECHG: rechg_reg <= pwdata[15:0];
          `REG_DISBAL: disbal_reg <= pwdata[15:0];
          `REG_MIN_TEMP: min_temp_reg <= pwdata[7:0];
          `REG_MAX_CUR: max_cur_reg <= pwdata[15:0];
          `REG_PRE_CUR: pre_cur_reg <= pwdata[15:0];
          `REG_CAPACITY: capacity_reg <= pwdata[15:0];
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      if (psel && !penable) begin
        pslverr <= paddr > `REG_REQ || paddr[1:0] != 2'h0
                   || (pwrite && charging && paddr != `REG_CTRL);
        case (paddr)
          `REG_CTRL: prdata <= {23'h0, err_reg, det_en_reg, 2'h0, can_mode_reg, start_reg};
          `REG_MAX_CELL: prdata <= {16'h0, max_cell_reg};
          `REG_MIN_CELL: prdata <= {16'h0, min_cell_reg};
          `REG_PRECHG: prdata <= {16'h0, prechg_reg};
          `REG_RECHG: prdata <= {16'h0, rechg_reg};
          `REG_DISBAL: prdata <= {16'h0, disbal_reg};
          `REG_MIN_TEMP: prdata <= {24'h0, min_temp_reg};
          `REG_MAX_CUR: prdata <= {16'h0, max_cur_reg};
          `REG_PRE_CUR: prdata <= {16'h0, pre_cur_reg};
          `REG_CAPACITY: prdata <= {16'h0, capacity_reg};
          `REG_STATUS: prdata <= {16'h0, soc_pct, 2'h0, connected, can_conn_reg, 1'b0, 3'(stage_reg)};
          `REG_CHARGE: prdata <= charge_reg[31:0];
          `REG_MINMAX: prdata <= {hi_mv, lo_mv};
          `REG_BAL: prdata <= {16'h0, bal_thr_reg};
          `REG_REQ: prdata <= {can_req_mv, can_req_da};
          default: prdata <= 32'h0;
        endcase
      end
    end
  end
endmodule

//--- src/rate_tick.sv
// Purpose: one-cycle enable pulse every PERIOD cycles
// Assumes: single clock
// Notes: PERIOD kept as a parameter so benches can shorten it
`timescale 1ns/1ps
module rate_tick #(
  parameter int PERIOD = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  output logic tick
);
  logic [31:0] cnt_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 32'h0;
      tick <= 1'b0;
    end else if (cnt_reg == 32'(PERIOD - 1)) begin
      cnt_reg <= 32'h0;
      tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 32'h1;
      tick <= 1'b0;
    end
  end
endmodule

//--- test/battery_charge_stage_control_tb.sv
// Purpose: self-checking bench for the charge stage controller
// Assumes: APB answers one cycle after setup; short periods below
// Notes: cells change only at a tick, so each burst averages one value
`timescale 1ns/1ps
`include "charge_cfg.svh"
module battery_charge_stage_control_tb;
  localparam int CP = 40;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, cell_sample_start, temp_sample_start, charger_enable, heater_on;
  logic contactor_close, can_req_valid, mains_present_input, can_rx_valid;
  logic cell_sample_valid = 1'b0;
  logic cur_valid = 1'b0;
  logic critical_fault = 1'b0;
  logic ac_on = 1'b1;
  logic talk = 1'b0;
  logic [1:0] model = 2'h0;
  logic [1:0] can_rx_model;
  logic [`N_CELLS*16-1:0] cells = {16{16'h0ed8}};
  logic signed [15:0] cur_da = 16'sh0000;
  logic signed [`N_TEMPS*8-1:0] temp_c = {5{8'sh19}};
  logic [15:0] can_req_mv, can_req_da;
  logic [`N_CELLS-1:0] shunt_on;
  logic [2:0] stage;
  logic [5:0] burst = 6'h00;
  int fails = 0;
  int n_tests = 0;
  always #2 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////////////////////
  charge_stage_ctrl #(.CELL_PERIOD(CP), .CUR_PERIOD(20), .TEMP_PERIOD(50), .CAN_TIMEOUT(200)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cell_sample_valid(cell_sample_valid), .cell_sample_mv(cells), .cur_valid(cur_valid),
    .cur_da(cur_da), .temp_c(temp_c), .critical_fault(critical_fault),
    .mains_present_input(mains_present_input), .can_rx_valid(can_rx_valid),
    .can_rx_model(can_rx_model), .cell_sample_start(cell_sample_start),
    .temp_sample_start(temp_sample_start), .charger_enable(charger_enable),
    .heater_on(heater_on), .contactor_close(contactor_close), .can_req_valid(can_req_valid),
    .can_req_mv(can_req_mv), .can_req_da(can_req_da), .shunt_on(shunt_on), .stage(stage));
  charger_model far (.pclk(pclk), .presetn(presetn), .ac_on(ac_on), .talk(talk), .model(model),
    .can_req_valid(can_req_valid), .mains_present_input(mains_present_input),
    .can_rx_valid(can_rx_valid), .can_rx_model(can_rx_model));
  // 32 samples right after each tick
  always @(posedge pclk) begin
    if (cell_sample_start === 1'b1) burst <= 6'h20;
    else if (burst != 6'h00) burst <= burst - 6'h01;
    cell_sample_valid <= (burst != 6'h00);
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    n_tests++;
    if (g !== x) begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic ex);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk($sformatf("read %h", a), x, r);
    chk("pslverr", {31'h0, ex}, {31'h0, e});
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic ex);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    chk("pslverr", {31'h0, ex}, {31'h0, e});
  endtask
  task automatic wait_stage(input logic [2:0] s);
    for (int i = 0; i < 400 && stage !== s; i++) @(negedge pclk);
    chk("stage", {29'h0, s}, {29'h0, stage});
  endtask
  task automatic setc(input logic [`N_CELLS*16-1:0] v);
    do @(posedge pclk); while (cell_sample_start !== 1'b1);
    cells <= v;
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    results();
  end
  initial begin
    static logic [31:0] rv [9] = '{32'h1068, 32'h0bb8, 32'h0c1c, 32'h1004, 32'h000a, 32'h0000,
                            32'h0064, 32'h000a, 32'h0064};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk("stage", 32'h0, {29'h0, stage});
    for (int i = 0; i < 9; i++) rd(12'(4 * i + 4), rv[i], 1'b0);
    rd(12'h03c, 32'h0, 1'b1);
    setc({{15{16'h0384}}, 16'h1388});
    repeat (2 * CP + 8) @(negedge pclk);
    rd(12'h030, 32'h119403e8, 1'b0);
    for (int i = 0; i < 4; i++) begin
      @(posedge pclk) cur_valid <= 1'b1;
      cur_da <= (i == 3) ? 16'sh02ef : 16'sh02ee;
      @(posedge pclk) cur_valid <= 1'b0;
    end
    rd(12'h02c, 32'h8ca, 1'b0);
    setc({16{16'h0ed8}});
    temp_c <= {{4{8'sh19}}, 8'shfb};
    wr(12'h000, 32'h1, 1'b0);
    wait_stage(3'h1);
    @(negedge pclk);
    chk("heater", 32'h1, {31'h0, heater_on});
    wr(12'h004, 32'h1000, 1'b1);
    rd(12'h004, 32'h1068, 1'b0);
    temp_c <= {5{8'sh19}};
    setc({{15{16'h0ed8}}, 16'h0bb8});
    wait_stage(3'h2);
    setc({16{16'h0ed8}});
    wait_stage(3'h3);
    @(negedge pclk);
    chk("charger", 32'h1, {31'h0, charger_enable});
    @(posedge pclk) critical_fault <= 1'b1;
    wait_stage(3'h6);
    @(posedge pclk) critical_fault <= 1'b0;
    wr(12'h000, 32'h101, 1'b0);
    wait_stage(3'h3);
    setc({{15{16'h1054}}, 16'h106d});
    wait_stage(3'h4);
    rd(12'h034, 32'h1068, 1'b0);
    chk("shunt", 32'h1, {16'h0, shunt_on});
    chk("charger", 32'h1, {31'h0, charger_enable});
    setc({{15{16'h1054}}, 16'h1077});
    repeat (2 * CP + 8) @(negedge pclk);
    chk("charger", 32'h0, {31'h0, charger_enable});
    rd(12'h034, 32'h105e, 1'b0);
    setc({{15{16'h1063}}, 16'h105e});
    wait_stage(3'h5);
    @(negedge pclk);
    chk("contactor", 32'h0, {31'h0, contactor_close});
    setc({{15{16'h1063}}, 16'h0fff});
    wait_stage(3'h3);
    @(posedge pclk) ac_on <= 1'b0;
    wait_stage(3'h0);
    wr(12'h000, 32'h13, 1'b0);
    rd(12'h000, 32'h13, 1'b0);
    model <= 2'h1;
    talk <= 1'b1;
    repeat (2 * CP + 8) @(negedge pclk);
    chk("stage", 32'h0, {29'h0, stage});
    @(posedge pclk) model <= 2'h0;
    wait_stage(3'h3);
    for (int i = 0; i < 50 && can_req_valid !== 1'b1; i++) @(negedge pclk);
    chk("request", 32'h0064, {16'h0, can_req_da});
    chk("request mv", 32'h1a40, {16'h0, can_req_mv});
    rd(12'h028, 32'h33, 1'b0);
    @(posedge pclk) talk <= 1'b0;
    wait_stage(3'h0);
    results();
  end
endmodule

//--- test/charge_stage_ctrl_asserts.sv
// Purpose: port checks for the charge stage controller
// Assumes: short bench periods handed in by the bind
// Notes: stage codes as in charge_pkg::stage_t
`timescale 1ns/1ps
module charge_stage_ctrl_asserts #(
  parameter int CELL_PERIOD = 40,
  parameter int TEMP_PERIOD = 50,
  parameter int CAN_TIMEOUT = 200
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic critical_fault,
  input wire logic can_rx_valid,
  input wire logic cell_sample_start,
  input wire logic temp_sample_start,
  input wire logic heater_on,
  input wire logic contactor_close,
  input wire logic can_req_valid,
  input wire logic [2:0] stage
);
  ////////////////////////////////////////////////////////////////////////////////
  // Held at zero until the first tick, so reset never reads as a short period
  logic [31:0] cell_cnt, temp_cnt, quiet_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cell_cnt <= 32'h0;
      temp_cnt <= 32'h0;
    end else begin
      cell_cnt <= cell_sample_start ? 32'h1 : cell_cnt + {31'h0, cell_cnt != 32'h0};
      temp_cnt <= temp_sample_start ? 32'h1 : temp_cnt + {31'h0, temp_cnt != 32'h0};
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quiet_cnt <= 32'h0;
    end else begin
      quiet_cnt <= can_rx_valid ? 32'h0 : quiet_cnt + 32'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_heat; stage == 3'h1 |-> heater_on; endproperty
  a_heat: assert property (p_heat) else $error("heater off in preheat");
  property p_fin; stage == 3'h5 |-> !contactor_close; endproperty
  a_fin: assert property (p_fin) else $error("contactor closed when finished");
  property p_fault; critical_fault && stage != 3'h0 |-> ##[1:2] stage == 3'h6; endproperty
  a_fault: assert property (p_fault) else $error("fault without error stage");
  property p_ready; psel && !penable |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  property p_refuse;
    psel && !penable && pwrite && paddr inside {[12'h004:12'h024]} && paddr[1:0] == 2'h0
      && stage != 3'h0 |=> pslverr;
  endproperty
  a_refuse: assert property (p_refuse) else $error("config write taken while charging");
  property p_cell; cell_sample_start && cell_cnt != 32'h0 |-> cell_cnt == CELL_PERIOD; endproperty
  a_cell: assert property (p_cell) else $error("cell sample period wrong");
  property p_temp; temp_sample_start && temp_cnt != 32'h0 |-> temp_cnt == TEMP_PERIOD; endproperty
  a_temp: assert property (p_temp) else $error("temperature period wrong");
  property p_quiet; can_req_valid |-> quiet_cnt <= CAN_TIMEOUT + 2; endproperty
  a_quiet: assert property (p_quiet) else $error("requests after charger silence");
endmodule
bind charge_stage_ctrl charge_stage_ctrl_asserts #(.CELL_PERIOD(CELL_PERIOD),
  .TEMP_PERIOD(TEMP_PERIOD), .CAN_TIMEOUT(CAN_TIMEOUT)) chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
  .pslverr(pslverr), .critical_fault(critical_fault), .can_rx_valid(can_rx_valid),
  .cell_sample_start(cell_sample_start), .temp_sample_start(temp_sample_start),
  .heater_on(heater_on), .contactor_close(contactor_close), .can_req_valid(can_req_valid),
  .stage(stage));

//--- test/charger_model.sv
// Purpose: far-side charger, plain mains sense or CAN messages
// Assumes: one message roughly every 32 cycles while talking
// Notes: also answers each request, as reply-type models do
`timescale 1ns/1ps
module charger_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ac_on,
  input wire logic talk,
  input wire logic [1:0] model,
  input wire logic can_req_valid,
  output logic mains_present_input,
  output logic can_rx_valid,
  output logic [1:0] can_rx_model
);
  logic [4:0] gap;
  assign mains_present_input = ac_on;
  assign can_rx_model = model;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap <= 5'h00;
      can_rx_valid <= 1'b0;
    end else begin
      gap <= gap + 5'h01;
      can_rx_valid <= talk && (gap == 5'h1f || can_req_valid);
    end
  end
endmodule
